// File: core/crid_regs.sv
// Receive buffer identifier registers with APB slave and frame load port.
`timescale 1ns/1ps
module crid_regs (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic                         clk_en,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [crid_pkg::CRID_AW-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         frame_load,
  input  wire logic [crid_pkg::CRID_EXT_W-1:0] frame_ident,
  input  wire logic                         frame_extended,
  input  wire logic                         frame_remote,
  output logic      [crid_pkg::CRID_EXT_W-1:0] ident_out,
  output logic                              ident_extended
);
  import crid_pkg::*;

  // Register bytes as software and the frame loader see them.
  logic [7:0]            regs      [CRID_NREG];
  // Next values of the register bytes, one per entry.
  logic [7:0]            next_regs [CRID_NREG];
  // Next value of the registered read data.
  logic [31:0]           next_prdata;
  // Next value of the registered ready pulse.
  logic                  next_pready;
  // Next value of the registered error answer.
  logic                  next_pslverr;
  // Index of the register that the bus address selects.
  logic [1:0]            sel_idx;
  // High when the bus address names one of the four registers.
  logic                  sel_hit;
  // High in an access cycle that still waits for its answer.
  logic                  acc_wait;
  // High at the edge on which the master sees the answer.
  logic                  acc_done;
  // High when a finishing transfer is a write that lands.
  logic                  wr_commit;
  // Next value of the rebuilt identifier.
  logic [CRID_EXT_W-1:0] next_ident_out;
  // Next value of the rebuilt extended-frame flag.
  logic                  next_ident_extended;

  // Carrier between the frame inputs and the byte packer.
  // Only the packer reads the identifier fields; the load pulse is read here.
  crid_load_if lp ();

  // The load pulse travels with its identifier so packer and registers agree.
  assign lp.load                   = frame_load;
  // The identifier is right aligned; standard frames use the low eleven bits.
  assign lp.ident                  = frame_ident;
  // Format flag of the received frame.
  assign lp.extended_frame_flag    = frame_extended;
  // Remote request bit; it only counts for extended frames.
  assign lp.substitute_remote_flag = frame_remote;

  // The packer turns one identifier into the four register images.
  crid_pack u_pack (
    .lp (lp)
  );

  // Address decode: each register sits on its own aligned word.
  // Any other address, unaligned ones included, is refused with an error.
  // The whole byte address is compared, so unaligned addresses always miss.
  always_comb begin
    // Start from a hit on the first register; the default branch clears the hit.
    sel_hit = 1'b1;
    sel_idx = 2'(CRID_IDX_IH);
    case (paddr)
      CRID_ADDR_IDENT_HIGH: begin
        // Identifier high byte.
        sel_idx = 2'(CRID_IDX_IH);
      end
      CRID_ADDR_IDENT_LOW: begin
        // Identifier low byte with the format flags.
        sel_idx = 2'(CRID_IDX_IL);
      end
      CRID_ADDR_EXT_IDENT_HIGH: begin
        // Extended identifier high byte.
        sel_idx = 2'(CRID_IDX_EH);
      end
      CRID_ADDR_EXT_IDENT_LOW: begin
        // Extended identifier low byte.
        sel_idx = 2'(CRID_IDX_EL);
      end
      default: begin
        // Unmapped word: no register answers it.
        sel_hit = 1'b0;
      end
    endcase
  end

  // Transfer phases of the bus.
  // The answer is registered, so an access waits one cycle with pready low.
  // A write is held back to the edge at which the master sees pready, so a
  // transfer that the master has not finished never changes a register.
  always_comb begin
    // Access phase not yet answered.
    acc_wait  = psel && penable && !pready;
    // Access phase that the master ends at this edge.
    acc_done  = psel && penable && pready;
    // Mapped write with the low byte lane enabled.
    wr_commit = acc_done && sel_hit && pwrite && pstrb[0];
  end

  // Next bus answer: a one-cycle pulse of pready with read data or an error.
  always_comb begin
    // Between transfers the answer lines rest at zero.
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    next_prdata  = '0;
    if (acc_wait) begin
      // The answer comes one cycle into the access phase.
      next_pready  = 1'b1;
      // An unmapped address is refused and reads back zero.
      next_pslverr = !sel_hit;
      if (sel_hit && !pwrite) begin
        // Only the low byte of the word carries a register.
        next_prdata = {CRID_ZERO_BYTE, CRID_ZERO_BYTE, CRID_ZERO_BYTE, regs[sel_idx]};
      end
    end
  end

  // Bus answer registers, frozen while the clock enable is low.
  // The answer stands for one cycle, then the lines fall back to zero.
  always_ff @(posedge clock) begin
    if (rst) begin
      // Reset leaves the bus idle.
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      // Run: take the computed answer.
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // One group of state per register byte.
  // Writing each byte once keeps the load, write and mask logic identical.
  for (genvar g = 0; g < CRID_NREG; g++) begin : g_byte
    // Bits that this byte can hold; the unimplemented low-byte bit is dropped.
    localparam logic [7:0] KEEP_MASK = (g == CRID_IDX_IL) ? CRID_LOW_MASK : ~CRID_ZERO_BYTE;

    // Next value: a frame load wins over a software write in the same cycle,
    // so a frame that arrives while software writes is never torn apart.
    always_comb begin
      // Hold the byte unless something below replaces it.
      next_regs[g] = regs[g];
      if (wr_commit && (sel_idx == 2'(g))) begin
        // Software writes the low byte of the bus word.
        next_regs[g] = pwdata[7:0];
      end
      if (lp.load) begin
        // A received frame replaces all four bytes at once.
        next_regs[g] = lp.byte_val[g];
      end
      // Bit 2 of the low byte never holds a one.
      next_regs[g] = next_regs[g] & KEEP_MASK;
    end

    // Byte register, cleared by reset and frozen while the clock enable is low.
    always_ff @(posedge clock) begin
      if (rst) begin
        // Contents after power-on are unknown; zero is chosen.
        regs[g] <= CRID_RESET_BYTE;
      end else if (clk_en) begin
        // Run: take the computed next value.
        regs[g] <= next_regs[g];
      end
    end
  end

  // Rebuild the identifier that the registers describe, one cycle behind them.
  // The extended flag in the low byte decides how the fields are read.
  always_comb begin
    // The flag comes straight from its register bit.
    next_ident_extended = regs[CRID_IDX_IL][CRID_LOW_EXT_BIT];
    if (next_ident_extended) begin
      // Extended: top bits, upper middle, middle, second byte, bottom byte.
      next_ident_out = {regs[CRID_IDX_IH],
                        regs[CRID_IDX_IL][CRID_LOW_STD_MSB:CRID_LOW_STD_LSB],
                        regs[CRID_IDX_IL][CRID_LOW_EID_MSB:CRID_LOW_EID_LSB],
                        regs[CRID_IDX_EH],
                        regs[CRID_IDX_EL]};
    end else begin
      // Standard: eleven bits, zero above them.
      next_ident_out = {{(CRID_EXT_W - CRID_STD_W){1'b0}},
                        regs[CRID_IDX_IH],
                        regs[CRID_IDX_IL][CRID_LOW_STD_MSB:CRID_LOW_STD_LSB]};
    end
  end

  // Identifier view registers, frozen while the clock enable is low.
  // Software writes to the bytes show up here as well as frame loads.
  always_ff @(posedge clock) begin
    if (rst) begin
      // Reset shows a zero standard identifier.
      ident_out      <= '0;
      ident_extended <= 1'b0;
    end else if (clk_en) begin
      // Run: take the rebuilt view.
      ident_out      <= next_ident_out;
      ident_extended <= next_ident_extended;
    end
  end
endmodule // crid_regs

// File: core/crid_pkg.sv
// Package with register map, field layout and widths of the receive identifier registers.
package crid_pkg;
  // Register byte addresses on the APB bus (one aligned word each).
  localparam logic [7:0] CRID_ADDR_IDENT_HIGH     = 8'h00;
  localparam logic [7:0] CRID_ADDR_IDENT_LOW      = 8'h04;
  localparam logic [7:0] CRID_ADDR_EXT_IDENT_HIGH = 8'h08;
  localparam logic [7:0] CRID_ADDR_EXT_IDENT_LOW  = 8'h0c;
  // Address width of the APB slave.
  localparam int CRID_AW = 8;
  // Number of byte registers.
  localparam int CRID_NREG = 4;
  // Register indices inside the register array.
  localparam int CRID_IDX_IH = 0;
  localparam int CRID_IDX_IL = 1;
  localparam int CRID_IDX_EH = 2;
  localparam int CRID_IDX_EL = 3;
  // Field positions in the identifier low byte.
  localparam int CRID_LOW_STD_MSB = 7;
  localparam int CRID_LOW_STD_LSB = 5;
  localparam int CRID_LOW_SRR_BIT = 4;
  localparam int CRID_LOW_EXT_BIT = 3;
  localparam int CRID_LOW_UNIMP_BIT = 2;
  // Extended identifier bits 17:16 sit at the bottom of the low byte.
  localparam int CRID_LOW_EID_MSB = 1;
  localparam int CRID_LOW_EID_LSB = 0;
  // Standard identifier pieces: bits 10:3 go high, bits 2:0 go low.
  localparam int CRID_STD_UP_MSB  = 10;
  localparam int CRID_STD_UP_LSB  = 3;
  localparam int CRID_STD_LOW_MSB = 2;
  localparam int CRID_STD_LOW_LSB = 0;
  // Extended identifier pieces, one entry per register field.
  localparam int CRID_EXT_TOP_MSB  = 28;
  localparam int CRID_EXT_TOP_LSB  = 21;
  localparam int CRID_EXT_UMID_MSB = 20;
  localparam int CRID_EXT_UMID_LSB = 18;
  localparam int CRID_EXT_MID_MSB  = 17;
  localparam int CRID_EXT_MID_LSB  = 16;
  localparam int CRID_EXT_SEC_MSB  = 15;
  localparam int CRID_EXT_SEC_LSB  = 8;
  localparam int CRID_EXT_BOT_MSB  = 7;
  localparam int CRID_EXT_BOT_LSB  = 0;
  // Mask of implemented bits in the low byte; bit 2 always reads zero.
  localparam logic [7:0] CRID_LOW_MASK = 8'hfb;
  // Value returned for implemented-bit-free positions.
  localparam logic [7:0] CRID_ZERO_BYTE = 8'h00;
  // Reset value chosen for registers documented as unknown after power-on.
  localparam logic [7:0] CRID_RESET_BYTE = 8'h00;
  // Identifier widths.
  localparam int CRID_STD_W = 11;
  localparam int CRID_EXT_W = 29;
endpackage : crid_pkg

// File: core/crid_load_if.sv
// Interface that carries a received frame's identifier from the capture stage to the registers.
`timescale 1ns/1ps
interface crid_load_if;
  logic                      load;           // One-cycle load of a new frame identifier.
  logic [crid_pkg::CRID_EXT_W-1:0] ident;    // Identifier, right aligned for standard frames.
  logic                      extended_frame_flag;    // Frame used the extended format.
  logic                      substitute_remote_flag; // Remote request bit of the frame.
  logic [7:0]                byte_val [crid_pkg::CRID_NREG]; // Packed register bytes.
  modport src (output load, output ident, output extended_frame_flag,
               output substitute_remote_flag, input byte_val);
  modport dst (input load, input ident, input extended_frame_flag,
               input substitute_remote_flag, output byte_val);
endinterface : crid_load_if

// File: core/crid_pack.sv
// Combinational packer that maps a frame identifier onto the four register byte images.
`timescale 1ns/1ps
module crid_pack (
  crid_load_if.dst lp
);
  import crid_pkg::*;

  // Standard and extended views of the identifier.
  logic [CRID_STD_W-1:0] std_id;
  logic [CRID_EXT_W-1:0] ext_id;

  // Split the identifier according to the frame format.
  always_comb begin
    std_id = lp.ident[CRID_STD_W-1:0];
    ext_id = lp.ident;
    if (lp.extended_frame_flag) begin
      // Extended frame: all four bytes carry identifier bits.
      lp.byte_val[CRID_IDX_IH] = ext_id[CRID_EXT_TOP_MSB:CRID_EXT_TOP_LSB];
      lp.byte_val[CRID_IDX_IL] = {ext_id[CRID_EXT_UMID_MSB:CRID_EXT_UMID_LSB],
                                  lp.substitute_remote_flag,
                                  1'b1,
                                  1'b0,
                                  ext_id[CRID_EXT_MID_MSB:CRID_EXT_MID_LSB]};
      lp.byte_val[CRID_IDX_EH] = ext_id[CRID_EXT_SEC_MSB:CRID_EXT_SEC_LSB];
      lp.byte_val[CRID_IDX_EL] = ext_id[CRID_EXT_BOT_MSB:CRID_EXT_BOT_LSB];
    end else begin
      // Standard frame: eleven bits, the rest of the bytes read zero.
      lp.byte_val[CRID_IDX_IH] = std_id[CRID_STD_UP_MSB:CRID_STD_UP_LSB];
      lp.byte_val[CRID_IDX_IL] = {std_id[CRID_STD_LOW_MSB:CRID_STD_LOW_LSB],
                                  CRID_ZERO_BYTE[CRID_LOW_SRR_BIT:0]};
      lp.byte_val[CRID_IDX_EH] = CRID_ZERO_BYTE;
      lp.byte_val[CRID_IDX_EL] = CRID_ZERO_BYTE;
    end
  end
endmodule // crid_pack

// File: bench/crid_props.sv
// Checker for bus timing, error answers and identifier rebuild of the identifier registers.
`timescale 1ns/1ps
module crid_props (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        frame_load,
  input wire logic [28:0] frame_ident,
  input wire logic        frame_extended,
  input wire logic [28:0] ident_out,
  input wire logic        ident_extended
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // A frame load, split by format, starts the rebuild check.
  sequence s_ext;
    frame_load && clk_en && frame_extended;
  endsequence
  sequence s_std;
    frame_load && clk_en && !frame_extended;
  endsequence
  a_ready_pulse: assert property (pready && clk_en |=> !pready) else $error("pready held too long");
  a_ready_wait: assert property (psel && penable && !pready && clk_en |=> pready)
    else $error("pready late");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper data set");
  a_unimp_zero: assert property (pready && !pwrite && paddr == 8'h04 |-> !prdata[2])
    else $error("low byte bit 2 set");
  a_bad_addr: assert property (pready && (paddr > 8'h0c || paddr[1:0] != 2'h0)
    |-> pslverr && prdata == 32'h0) else $error("unmapped access accepted");
  a_good_addr: assert property (pready && paddr <= 8'h0c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_ext_rebuild: assert property (
    s_ext |-> ##2 ident_extended && ident_out == $past(frame_ident, 2))
    else $error("extended identifier wrong");
  a_std_rebuild: assert property (
    s_std |-> ##2 !ident_extended && ident_out == ($past(frame_ident, 2) & 29'h7ff))
    else $error("standard identifier wrong");
  // A low clock enable freezes the bus answer and the identifier view.
  a_freeze_hold: assert property (!clk_en |=> $stable(pready) && $stable(prdata)
    && $stable(ident_out) && $stable(ident_extended)) else $error("state moved while frozen");
endmodule // crid_props
bind crid_regs crid_props chk_u (.clock, .rst, .clk_en, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .frame_load, .frame_ident, .frame_extended, .ident_out,
  .ident_extended);

// File: bench/crid_node.sv
// Model of the receiving side that hands accepted frame identifiers to the registers.
`timescale 1ns/1ps
module crid_node (
  input  wire logic                          clock,
  output logic                               frame_load,
  output logic [crid_pkg::CRID_EXT_W-1:0]    frame_ident,
  output logic                               frame_extended,
  output logic                               frame_remote
);
  initial begin
    frame_load = 1'b0;
    frame_ident = '0;
    frame_extended = 1'b0;
    frame_remote = 1'b0;
  end
  // Pulses one frame in, then turns the released lines over so stale values never match.
  task automatic send(input logic [28:0] id, input logic x, input logic rm);
    @(posedge clock);
    frame_load <= 1'b1;
    frame_ident <= id;
    frame_extended <= x;
    frame_remote <= rm;
    @(posedge clock);
    frame_load <= 1'b0;
    frame_ident <= ~id;
    frame_extended <= ~x;
    frame_remote <= ~rm;
    repeat (3) @(posedge clock);
  endtask
endmodule // crid_node

// File: bench/tb.sv
// Self-checking bench for the receive identifier registers.
`timescale 1ns/1ps
module tb;
  import crid_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  // Clock enable and byte lanes, driven so that freezing and lane gating are exercised.
  logic        clk_en = 1'b1;
  logic [3:0]  pstrb = 4'h1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, frame_load, frame_extended, frame_remote, ident_extended;
  logic [28:0] frame_ident, ident_out;
  logic [7:0]  ex [4];
  int          n_fail = 0, tests_run = 0, cyc = 0;
  always #25 clock = ~clock;
  crid_node node_u (.clock, .frame_load, .frame_ident, .frame_extended, .frame_remote);
  crid_regs dut_u (.clock, .rst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .frame_load, .frame_ident, .frame_extended,
    .frame_remote, .ident_out, .ident_extended);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", n, x, s);
    end
  endtask
  // One APB transfer; the request stands until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads all four bytes, then checks the identifier view that they describe.
  task automatic rd_all(input string n);
    logic [28:0] id_x;
    // The extended flag in the low byte selects how the bytes join up.
    id_x = ex[1][3] ? {ex[0], ex[1][7:5], ex[1][1:0], ex[2], ex[3]}
                    : {18'h0, ex[0], ex[1][7:5]};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(n, rd, {24'h0, ex[i]});
    end
    chk("ident", {3'h0, ident_out}, {3'h0, id_x});
    chk("ext_flag", {31'h0, ident_extended}, {31'h0, ex[1][3]});
    $display("%s test done", n);
  endtask
  // Loads a frame through the model and reads back all four bytes.
  task automatic t_frame(input logic [28:0] id, input logic x, input logic rm);
    node_u.send(id, x, rm);
    chk("ident_id", {3'h0, ident_out}, {3'h0, x ? id : {18'h0, id[10:0]}});
    ex[0] = x ? id[28:21] : id[10:3];
    ex[1] = x ? {id[20:18], rm, 1'b1, 1'b0, id[17:16]} : {id[2:0], 5'h0};
    ex[2] = x ? id[15:8] : 8'h00;
    ex[3] = x ? id[7:0] : 8'h00;
    rd_all(x ? "ext" : "std");
  endtask
  // Software writes every byte; a write with its lane off and an unmapped write change nothing.
  task automatic t_sw;
    apb(1'b1, 8'h04, 32'hff);
    apb(1'b1, 8'h0c, 32'h5a);
    apb(1'b1, 8'h00, 32'ha5);
    apb(1'b1, 8'h08, 32'h3c);
    // Low byte lane off: the high byte must keep its value.
    pstrb <= 4'he;
    apb(1'b1, 8'h00, 32'h77);
    pstrb <= 4'h1;
    apb(1'b1, 8'h10, 32'hff);
    chk("slverr", {31'h0, er}, 32'h1);
    ex = '{8'ha5, 8'hfb, 8'h3c, 8'h5a};
    rd_all("sw");
  endtask
  // A frame offered while the clock enable is low must leave every byte as it was.
  task automatic t_freeze;
    @(posedge clock);
    clk_en <= 1'b0;
    node_u.send(29'h0f0f0f0f, 1'b1, 1'b1);
    clk_en <= 1'b1;
    rd_all("freeze");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict;
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    ex = '{default: 8'h00};
    rd_all("reset");
    t_frame(29'h1abcdef5, 1'b1, 1'b1);
    t_frame(29'h0542a6b3, 1'b1, 1'b0);
    t_frame(29'h000005a3, 1'b0, 1'b1);
    t_freeze;
    t_sw;
    give_verdict;
  end
endmodule // tb
